// ---- hw/pds_pkg.sv ----
// constants for the pll output divider sync block
//------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------
// Overview of operation
// - During a sync event every output divider is aligned to the feedback divider output.
// - The multi-function sync pin lets the external controller request synchronization.
// - A software sync bit serves as an alternative request source to the pin.
// - In the first aligned mode one chosen output divider is placed in the feedback path.
// - In the second aligned mode a delay matching the output dividers follows the feedback divider.
// - With aligned mode off the feedback divider output goes straight to the phase detector.
// - Without aligned mode outputs still keep cycle alignment to the feedback divider while locked.
// - Pin and software bit are ORed, retimed to the input clock and then to the feedback divider output.
// - After a rising request each divider runs until its output is low, then holds low.
// - On the retimed falling request the dividers are armed and then the clock is released to them.
package pds_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned DIV_W = 8;
	localparam int unsigned NUM_OUT = 4;
	localparam int unsigned DLY_W = 4;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_LOOP_DIV = 2'h1;
	localparam logic [1:0] MODE_DELAY = 2'h2;
	localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
	localparam logic [DIV_W-1:0] CNT_ZERO = 8'h00;
	localparam logic [DLY_W-1:0] DLY_ZERO = 4'h0;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_INIT = 2'b01,
		ST_ARM = 2'b10,
		ST_RELEASE = 2'b11
	} pds_state_e;
endpackage : pds_pkg

// ---- hw/pds_out_div.sv ----
// one output divider with freeze and arm control
`timescale 1ns/1ns
module pds_out_div #(
	parameter int unsigned DIV_W = pds_pkg::DIV_W
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [DIV_W-1:0] ratio,
	input wire logic freeze_req,
	input wire logic arm,
	input wire logic clk_gate,
	output logic div_out,
	output logic frozen
);
	logic [DIV_W-1:0] cnt_q, cnt_d;
	logic out_q, out_d;
	logic frz_q, frz_d;
	logic [DIV_W-1:0] half;
	assign half = ratio >> 1;
	always_comb begin
		cnt_d = cnt_q;
		out_d = out_q;
		frz_d = frz_q;
		if (arm) begin
			cnt_d = pds_pkg::CNT_ZERO;
			out_d = 1'b0;
			frz_d = 1'b0;
		end else if (clk_gate && !frz_q) begin
			if (ratio <= pds_pkg::DIV_ONE) begin
				out_d = ~out_q;
			end else if (cnt_q >= ratio - pds_pkg::DIV_ONE) begin
				cnt_d = pds_pkg::CNT_ZERO;
				out_d = 1'b1;
			end else begin
				cnt_d = cnt_q + pds_pkg::DIV_ONE;
				if (cnt_q + pds_pkg::DIV_ONE == half) begin
					out_d = 1'b0;
				end
			end
			// stop once the output has fallen from high to low
			if (freeze_req && out_q && !out_d) begin
				frz_d = 1'b1;
			end
			if (freeze_req && !out_q) begin
				frz_d = 1'b1;
				out_d = 1'b0;
				cnt_d = cnt_q;
			end
		end
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= pds_pkg::CNT_ZERO;
			out_q <= 1'b0;
			frz_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			out_q <= out_d;
			frz_q <= frz_d;
		end
	end
	assign div_out = out_q;
	assign frozen = frz_q;
	property p_frozen_low;
		@(posedge mclk) disable iff (!rstn)
		frz_q |-> !out_q;
	endproperty
	a_frozen_low: assert property (p_frozen_low) else $error("frozen divider output not low");
	property p_frozen_hold;
		@(posedge mclk) disable iff (!rstn)
		(frz_q && !arm) |=> (frz_q && $stable(cnt_q));
	endproperty
	a_frozen_hold: assert property (p_frozen_hold) else $error("frozen divider moved");
endmodule : pds_out_div

// ---- hw/pds_sync_top.sv ----
// sync request retiming, divider alignment and feedback path select
`timescale 1ns/1ns
module pds_sync_top #(
	parameter int unsigned NUM_OUT = pds_pkg::NUM_OUT,
	parameter int unsigned DIV_W = pds_pkg::DIV_W,
	parameter int unsigned DLY_W = pds_pkg::DLY_W
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic multi_function_sync_pin,
	input wire logic sw_sync_wr,
	input wire logic sw_sync_wdata,
	output logic software_sync_bit,
	input wire logic [DIV_W-1:0] feedback_ratio,
	input wire logic [NUM_OUT*DIV_W-1:0] out_ratio,
	input wire logic [1:0] reference_aligned_output_mode,
	input wire logic [$clog2(NUM_OUT)-1:0] loop_div_sel,
	input wire logic [DLY_W-1:0] match_delay,
	output logic [NUM_OUT-1:0] div_out,
	output logic feedback_divider,
	output logic phase_detector_fb,
	output logic [1:0] sync_state,
	output logic all_frozen
);
	// ------------------------------------------------------------
	// software sync bit and request combine
	// ------------------------------------------------------------
	logic sw_q, sw_d;
	logic pin_m_q, pin_s_q;
	logic req_m_q, req_s_q;
	logic req_fb_q, req_fb_d;
	logic fb_prev_q;
	logic fb_edge;
	always_comb begin
		sw_d = sw_q;
		if (sw_sync_wr) begin
			sw_d = sw_sync_wdata;
		end
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sw_q <= 1'b0;
			pin_m_q <= 1'b0;
			pin_s_q <= 1'b0;
			req_m_q <= 1'b0;
			req_s_q <= 1'b0;
		end else begin
			sw_q <= sw_d;
			pin_m_q <= multi_function_sync_pin;
			pin_s_q <= pin_m_q;
			req_m_q <= pin_s_q | sw_q;
			req_s_q <= req_m_q;
		end
	end
	assign software_sync_bit = sw_q;
	// ------------------------------------------------------------
	// feedback divider and retime to its output
	// ------------------------------------------------------------
	logic [DIV_W-1:0] fcnt_q, fcnt_d;
	logic fout_q, fout_d;
	always_comb begin
		fcnt_d = fcnt_q + pds_pkg::DIV_ONE;
		fout_d = fout_q;
		if (fcnt_q >= feedback_ratio - pds_pkg::DIV_ONE) begin
			fcnt_d = pds_pkg::CNT_ZERO;
			fout_d = 1'b1;
		end else if (fcnt_q + pds_pkg::DIV_ONE == (feedback_ratio >> 1)) begin
			fout_d = 1'b0;
		end
		if (feedback_ratio <= pds_pkg::DIV_ONE) begin
			fcnt_d = pds_pkg::CNT_ZERO;
			fout_d = ~fout_q;
		end
	end
	assign fb_edge = fout_q && !fb_prev_q;
	always_comb begin
		req_fb_d = req_fb_q;
		if (fb_edge) begin
			req_fb_d = req_s_q;
		end
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			fcnt_q <= pds_pkg::CNT_ZERO;
			fout_q <= 1'b0;
			fb_prev_q <= 1'b0;
			req_fb_q <= 1'b0;
		end else begin
			fcnt_q <= fcnt_d;
			fout_q <= fout_d;
			fb_prev_q <= fout_q;
			req_fb_q <= req_fb_d;
		end
	end
	assign feedback_divider = fout_q;
	// ------------------------------------------------------------
	// sync state machine
	// ------------------------------------------------------------
	pds_pkg::pds_state_e st_q, st_d;
	logic arm;
	logic freeze_req;
	logic clk_gate;
	logic [NUM_OUT-1:0] frozen;
	always_comb begin
		st_d = st_q;
		case (st_q)
			pds_pkg::ST_IDLE: begin
				if (req_fb_q) begin
					st_d = pds_pkg::ST_INIT;
				end
			end
			pds_pkg::ST_INIT: begin
				if (!req_fb_q && (&frozen)) begin
					st_d = pds_pkg::ST_ARM;
				end
			end
			pds_pkg::ST_ARM: begin
				st_d = pds_pkg::ST_RELEASE;
			end
			pds_pkg::ST_RELEASE: begin
				st_d = pds_pkg::ST_IDLE;
			end
			default: begin
				st_d = pds_pkg::ST_IDLE;
			end
		endcase
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_q <= pds_pkg::ST_IDLE;
		end else begin
			st_q <= st_d;
		end
	end
	assign freeze_req = (st_q == pds_pkg::ST_INIT);
	// release follows the request that falls on a feedback edge, once all dividers are frozen, so outputs restart aligned to it
	assign arm = (st_q == pds_pkg::ST_ARM);
	assign clk_gate = (st_q != pds_pkg::ST_ARM);
	assign sync_state = st_q;
	assign all_frozen = &frozen;
	// ------------------------------------------------------------
	// output dividers
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_OUT; gi++) begin : g_div
			pds_out_div #(
				.DIV_W(DIV_W)
			) u_div (
				.mclk(mclk),
				.rstn(rstn),
				.ratio(out_ratio[gi*DIV_W +: DIV_W]),
				.freeze_req(freeze_req),
				.arm(arm),
				.clk_gate(clk_gate),
				.div_out(div_out[gi]),
				.frozen(frozen[gi])
			);
		end
	endgenerate
	// ------------------------------------------------------------
	// phase detector feedback path select
	// ------------------------------------------------------------
	localparam logic [DLY_W-1:0] DLY_STEP = DLY_W'(1);
	logic [(1<<DLY_W)-1:0] dly_q, dly_d;
	logic fb_mux;
	always_comb begin
		dly_d = {dly_q[(1<<DLY_W)-2:0], fout_q};
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dly_q <= '0;
		end else begin
			dly_q <= dly_d;
		end
	end
	always_comb begin
		case (reference_aligned_output_mode)
			pds_pkg::MODE_LOOP_DIV: fb_mux = div_out[loop_div_sel];
			pds_pkg::MODE_DELAY: fb_mux = (match_delay == pds_pkg::DLY_ZERO) ? fout_q : dly_q[match_delay - DLY_STEP];
			default: fb_mux = fout_q;
		endcase
	end
	assign phase_detector_fb = fb_mux;
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_or_combine;
		@(posedge mclk) disable iff (!rstn)
		req_m_q == $past(pin_s_q | sw_q);
	endproperty
	a_or_combine: assert property (p_or_combine) else $error("request not ORed");
	property p_fb_retime;
		@(posedge mclk) disable iff (!rstn)
		!fb_edge |=> $stable(req_fb_q);
	endproperty
	a_fb_retime: assert property (p_fb_retime) else $error("request changed off feedback edge");
	property p_idle_free;
		@(posedge mclk) disable iff (!rstn)
		(st_q == pds_pkg::ST_IDLE) |-> (frozen == '0);
	endproperty
	a_idle_free: assert property (p_idle_free) else $error("dividers held in idle");
	property p_start_init;
		@(posedge mclk) disable iff (!rstn)
		(st_q == pds_pkg::ST_IDLE && req_fb_q) |=> st_q == pds_pkg::ST_INIT;
	endproperty
	a_start_init: assert property (p_start_init) else $error("no init on request");
	property p_arm_release;
		@(posedge mclk) disable iff (!rstn)
		(st_q == pds_pkg::ST_ARM) |=> (st_q == pds_pkg::ST_RELEASE && clk_gate);
	endproperty
	a_arm_release: assert property (p_arm_release) else $error("arm not followed by release");
	property p_complete;
		@(posedge mclk) disable iff (!rstn)
		(st_q == pds_pkg::ST_INIT && !req_fb_q && (&frozen)) |=> arm;
	endproperty
	a_complete: assert property (p_complete) else $error("no arm on falling request");
	property p_armed_low;
		@(posedge mclk) disable iff (!rstn)
		arm |=> (div_out == '0);
	endproperty
	a_armed_low: assert property (p_armed_low) else $error("outputs not aligned low after arm");
	property p_direct_fb;
		@(posedge mclk) disable iff (!rstn)
		(reference_aligned_output_mode == pds_pkg::MODE_OFF) |-> phase_detector_fb == fout_q;
	endproperty
	a_direct_fb: assert property (p_direct_fb) else $error("direct path broken");
	property p_loop_div;
		@(posedge mclk) disable iff (!rstn)
		(reference_aligned_output_mode == pds_pkg::MODE_LOOP_DIV) |-> phase_detector_fb == div_out[loop_div_sel];
	endproperty
	a_loop_div: assert property (p_loop_div) else $error("loop divider not selected");
	property p_sw_write;
		@(posedge mclk) disable iff (!rstn)
		sw_sync_wr |=> software_sync_bit == $past(sw_sync_wdata);
	endproperty
	a_sw_write: assert property (p_sw_write) else $error("software bit not written");
endmodule : pds_sync_top

// ---- tb/pds_sync_ctl.sv ----
// far side sync controller model driving the sync pin
`timescale 1ns/1ns
module pds_sync_ctl #(
	parameter int unsigned HOLD = 64
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic go,
	output logic pin
);
	int unsigned cnt;
	// pin follows go but stays high at least HOLD cycles, shortened from the real hold time
	always @(negedge mclk or negedge rstn) begin
		if (!rstn) begin
			pin <= 1'b0;
			cnt <= 0;
		end else if (go || (pin && cnt < HOLD)) begin
			pin <= 1'b1;
			cnt <= cnt + 1;
		end else begin
			pin <= 1'b0;
			cnt <= 0;
		end
	end
endmodule : pds_sync_ctl

// ---- tb/pds_sync_top_test.sv ----
// self-checking bench for the sync top
`timescale 1ns/1ns
module pds_sync_top_test;
	typedef struct packed {logic [1:0] m; logic [1:0] s; logic [3:0] d; logic lp; logic [3:0] ed;} pds_row_s;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic go = 1'b0;
	logic pin;
	logic sw_sync_wr = 1'b0;
	logic sw_sync_wdata = 1'b0;
	logic software_sync_bit;
	logic [7:0] feedback_ratio = 8'h06;
	logic [31:0] out_ratio = 32'h06060303;
	logic [1:0] mode = 2'h0;
	logic [1:0] loop_div_sel = 2'h0;
	logic [3:0] match_delay = 4'h0;
	logic [3:0] div_out;
	logic feedback_divider;
	logic phase_detector_fb;
	logic [1:0] sync_state;
	logic all_frozen;
	logic [15:0] fb_hist = 16'h0000;
	logic [16:0] h;
	int err_count = 0;
	int checks = 0;
	int n;
	pds_row_s rows [6] = '{
		'{2'h0, 2'h0, 4'h5, 1'b0, 4'h0}, '{2'h1, 2'h2, 4'h0, 1'b1, 4'h0},
		'{2'h1, 2'h3, 4'h0, 1'b1, 4'h0}, '{2'h2, 2'h0, 4'h0, 1'b0, 4'h0},
		'{2'h2, 2'h0, 4'h3, 1'b0, 4'h3}, '{2'h3, 2'h0, 4'h7, 1'b0, 4'h0}};

	always #5 mclk = ~mclk;
	always @(posedge mclk) fb_hist <= {fb_hist[14:0], feedback_divider};
	assign h = {fb_hist, feedback_divider};

	pds_sync_ctl ctl (.mclk(mclk), .rstn(rstn), .go(go), .pin(pin));

	pds_sync_top dut (
		.mclk(mclk), .rstn(rstn), .multi_function_sync_pin(pin), .sw_sync_wr(sw_sync_wr),
		.sw_sync_wdata(sw_sync_wdata), .software_sync_bit(software_sync_bit),
		.feedback_ratio(feedback_ratio), .out_ratio(out_ratio), .reference_aligned_output_mode(mode),
		.loop_div_sel(loop_div_sel), .match_delay(match_delay), .div_out(div_out),
		.feedback_divider(feedback_divider), .phase_detector_fb(phase_detector_fb),
		.sync_state(sync_state), .all_frozen(all_frozen));

	//------------------------------------------------------------
	// helpers
	//------------------------------------------------------------
	task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk

	task automatic wait_st(input logic [1:0] st);
		for (n = 0; n < 400 && sync_state !== st; n++) @(negedge mclk);
		chk(sync_state, st, "state not reached");
	endtask : wait_st

	task automatic swwr(input logic v);
		sw_sync_wr = 1'b1;
		sw_sync_wdata = v;
		@(negedge mclk);
		sw_sync_wr = 1'b0;
		chk(software_sync_bit, v, "sw bit readback");
	endtask : swwr

	task automatic sync_cycle(input logic use_sw);
		// knock the dividers out of phase so that the sync has work to do
		out_ratio = 32'h07060304;
		repeat (7) @(negedge mclk);
		out_ratio = 32'h06060303;
		repeat (8) @(negedge mclk);
		if (use_sw) swwr(1'b1);
		else go = 1'b1;
		wait_st(pds_pkg::ST_INIT);
		for (n = 0; n < 400 && all_frozen !== 1'b1; n++) @(negedge mclk);
		chk(all_frozen, 1'b1, "dividers not frozen");
		repeat (4) begin
			@(negedge mclk);
			chk(div_out, 4'h0, "frozen output not low");
		end
		if (use_sw) swwr(1'b0);
		else go = 1'b0;
		wait_st(pds_pkg::ST_ARM);
		@(negedge mclk);
		chk(sync_state, pds_pkg::ST_RELEASE, "no release");
		@(negedge mclk);
		chk(sync_state, pds_pkg::ST_IDLE, "no return to idle");
		repeat (40) begin
			@(negedge mclk);
			chk({div_out[1], div_out[3]}, {div_out[0], div_out[2]}, "outputs not aligned");
			if (h[0] && !h[1]) chk(div_out[1:0], 2'h3, "outputs not aligned to feedback");
		end
	endtask : sync_cycle

	task automatic results;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results

	//------------------------------------------------------------
	// main sequence
	//------------------------------------------------------------
	initial begin
		repeat (10) @(negedge mclk);
		chk(sync_state, pds_pkg::ST_IDLE, "reset state");
		chk(software_sync_bit, 1'b0, "reset sw bit");
		chk(div_out, 4'h0, "reset outputs");
		rstn = 1'b1;
		for (n = 0; n < 40 && div_out[0] !== 1'b1; n++) @(negedge mclk);
		chk(div_out[0], 1'b1, "divider not running");
		foreach (rows[i]) begin
			mode = rows[i].m;
			loop_div_sel = rows[i].s;
			match_delay = rows[i].d;
			repeat (20) @(negedge mclk);
			repeat (16) begin
				@(negedge mclk);
				chk(phase_detector_fb, rows[i].lp ? div_out[rows[i].s] : h[rows[i].ed], "fb path");
			end
		end
		mode = pds_pkg::MODE_OFF;
		sync_cycle(1'b0);
		mode = pds_pkg::MODE_LOOP_DIV;
		loop_div_sel = 2'h2;
		sync_cycle(1'b1);
		go = 1'b1;
		wait_st(pds_pkg::ST_INIT);
		rstn = 1'b0;
		go = 1'b0;
		@(negedge mclk);
		chk(sync_state, pds_pkg::ST_IDLE, "mid-run reset");
		chk(div_out, 4'h0, "mid-run reset outputs");
		chk(all_frozen, 1'b0, "mid-run reset frozen");
		rstn = 1'b1;
		repeat (100) @(negedge mclk);
		chk(sync_state, pds_pkg::ST_IDLE, "stays idle");
		results;
	end

	initial begin
		#200000;
		err_count++;
		results;
	end
endmodule : pds_sync_top_test
